// File: shared/oamd_pkg.sv
// Shared constants, mode codes and decode functions of the operand address mode decoder.
package oamd_pkg;

	// ====================================================================
	// Widths and fixed values
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned MODE_W     = 5;
	localparam logic [7:0]  PREFIX_Y   = 8'h90;
	localparam logic [7:0]  PAGE_ZERO  = 8'h00;
	localparam logic [15:0] ADDR_RST   = 16'h0000;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [1:0]  CNT_RST    = 2'h0;

	// ====================================================================
	// Addressing modes, seventeen codes in seven groups
	typedef enum logic [MODE_W-1:0] {
		M_INH   = 5'h00,
		M_IMM   = 5'h01,
		M_DIR_S = 5'h02,
		M_DIR_L = 5'h03,
		M_IDX_0 = 5'h04,
		M_IDX_S = 5'h05,
		M_IDX_L = 5'h06,
		M_IND_S = 5'h07,
		M_IND_L = 5'h08,
		M_IIX_S = 5'h09,
		M_IIX_L = 5'h0A,
		M_REL_D = 5'h0B,
		M_REL_I = 5'h0C,
		M_BIT_D = 5'h0D,
		M_BIT_I = 5'h0E,
		M_BTJ_D = 5'h0F,
		M_BTJ_I = 5'h10
	} oamd_mode_t;

	localparam logic [MODE_W-1:0] MODE_LAST = 5'h10;

	// ====================================================================
	// Decode functions
	function automatic logic [1:0] oamd_ext_bytes(input oamd_mode_t m);
		case (m)
			M_INH, M_IDX_0:                  oamd_ext_bytes = 2'h0;
			M_DIR_L, M_IDX_L, M_BTJ_D, M_BTJ_I: oamd_ext_bytes = 2'h2;
			default:                         oamd_ext_bytes = 2'h1;
		endcase
	endfunction

	function automatic logic [1:0] oamd_ptr_bytes(input oamd_mode_t m);
		case (m)
			M_IND_S, M_IIX_S, M_REL_I, M_BIT_I, M_BTJ_I: oamd_ptr_bytes = 2'h1;
			M_IND_L, M_IIX_L:                            oamd_ptr_bytes = 2'h2;
			default:                                     oamd_ptr_bytes = 2'h0;
		endcase
	endfunction

	function automatic logic oamd_is_long(input oamd_mode_t m);
		oamd_is_long = (m == M_DIR_L) || (m == M_IDX_L) || (m == M_IND_L) || (m == M_IIX_L);
	endfunction

	function automatic logic oamd_has_target(input oamd_mode_t m);
		oamd_has_target = (m == M_REL_D) || (m == M_REL_I) || (m == M_BTJ_D) || (m == M_BTJ_I);
	endfunction

	function automatic logic oamd_has_ea(input oamd_mode_t m);
		oamd_has_ea = !((m == M_INH) || (m == M_IMM) || (m == M_REL_D) || (m == M_REL_I));
	endfunction

	function automatic logic oamd_y_applies(input oamd_mode_t m);
		oamd_y_applies = (m == M_INH) || (m == M_IMM) || (m == M_DIR_S) || (m == M_DIR_L) ||
			(m == M_IDX_0) || (m == M_IDX_S) || (m == M_IDX_L);
	endfunction

endpackage

// File: shared/oamd_ea_if.sv
// Interface between the decoder sequencer and its address arithmetic.
`timescale 1ns/1ps
`default_nettype none
interface oamd_ea_if;
	import oamd_pkg::*;

	oamd_mode_t  mode;
	logic [7:0]  index;
	logic [7:0]  ext_hi;
	logic [7:0]  ext_lo;
	logic [15:0] ptr;
	logic [15:0] pc_next;
	logic [15:0] ea;
	logic [15:0] target;

	modport calc (
		input  mode,
		input  index,
		input  ext_hi,
		input  ext_lo,
		input  ptr,
		input  pc_next,
		output ea,
		output target
	);

	modport seq (
		output mode,
		output index,
		output ext_hi,
		output ext_lo,
		output ptr,
		output pc_next,
		input  ea,
		input  target
	);
endinterface
`default_nettype wire

// File: rtl/oamd_ea_calc.sv
// Effective address and branch target arithmetic for every addressing mode.
`timescale 1ns/1ps
`default_nettype none
module oamd_ea_calc (
	// Operands in, results out
	oamd_ea_if.calc ifc
);
	import oamd_pkg::*;

	logic [15:0] idx16;
	logic [15:0] rel_base;
	logic [7:0]  rel_off;

	always_comb begin
		idx16    = {PAGE_ZERO, ifc.index};
		rel_off  = ifc.ext_hi;
		ifc.ea   = ADDR_RST;
		case (ifc.mode)
			M_DIR_S, M_BIT_D, M_BTJ_D: ifc.ea = {PAGE_ZERO, ifc.ext_hi};
			M_DIR_L: ifc.ea = {ifc.ext_hi, ifc.ext_lo};
			M_IDX_0: ifc.ea = idx16;
			// Nine bit sum kept whole, so short indexing reaches 1FE.
			M_IDX_S: ifc.ea = {PAGE_ZERO, ifc.ext_hi} + idx16;
			M_IDX_L: ifc.ea = {ifc.ext_hi, ifc.ext_lo} + idx16;
			M_IND_S, M_BIT_I, M_BTJ_I: ifc.ea = {PAGE_ZERO, ifc.ptr[7:0]};
			M_IND_L: ifc.ea = ifc.ptr;
			M_IIX_S: ifc.ea = {PAGE_ZERO, ifc.ptr[7:0]} + idx16;
			M_IIX_L: ifc.ea = ifc.ptr + idx16;
			default: ifc.ea = ADDR_RST;
		endcase
		case (ifc.mode)
			M_REL_I: rel_off = ifc.ptr[7:0];
			M_BTJ_D, M_BTJ_I: rel_off = ifc.ext_lo;
			default: rel_off = ifc.ext_hi;
		endcase
		rel_base   = ifc.pc_next;
		ifc.target = rel_base + {{8{rel_off[7]}}, rel_off};
	end
endmodule
`default_nettype wire

// File: rtl/oamd_top.sv
// Operand addressing mode decoder: fetches extension bytes, reads pointers, forms addresses.
//
// Behaviour
// - Seventeen addressing modes in seven groups are decoded.
// - Short forms give addresses in page zero, 0000 to 00FF, except short indexed forms, which reach 01FE.
// - Long forms reach the whole 64 Kbyte space with more bytes.
// - Read-modify-write instructions are refused with any long mode.
// - Inherent instructions are one byte; no extension bytes fetched.
// - Immediate takes the byte after the opcode as operand value.
// - Short direct uses one fetched byte as address 00 to FF.
// - Long direct uses a fetched two byte word as address.
// - Indexed address is unsigned sum of index register and offset.
// - Indexed without offset fetches nothing and uses the index alone.
// - Short indexed adds a byte offset, giving 00 to 1FE unwrapped.
// - Long indexed adds a word offset, reaching all of 64 Kbyte.
// - Branch targets span minus 128 to plus 127 from next instruction.
// - Indirect fetches a pointer address, then reads byte or word pointer.
// - Indirect indexed adds the index unsigned to the pointer read.
// - Relative adds a signed 8-bit offset from instruction or memory.
// - Prefix byte 90 swaps X for Y in listed modes.
`timescale 1ns/1ps
`default_nettype none
module oamd_top (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_i,
	// Instruction fetch stream
	input  wire logic                          fetch_valid_i,
	input  wire logic [oamd_pkg::DATA_W-1:0]   fetch_byte_i,
	input  wire logic [oamd_pkg::ADDR_W-1:0]   fetch_pc_i,
	input  wire logic [oamd_pkg::MODE_W-1:0]   fetch_mode_i,
	input  wire logic                          fetch_rmw_i,
	output logic                               fetch_ready_o,
	output logic                               ext_valid_o,
	output logic [1:0]                         ext_count_o,
	// Index registers
	input  wire logic [oamd_pkg::DATA_W-1:0]   x_i,
	input  wire logic [oamd_pkg::DATA_W-1:0]   y_i,
	// Data memory read port
	output logic                               mem_req_o,
	output logic [oamd_pkg::ADDR_W-1:0]        mem_addr_o,
	input  wire logic                          mem_ack_i,
	input  wire logic [oamd_pkg::DATA_W-1:0]   mem_rdata_i,
	// Decoded result
	output logic                               done_o,
	output logic                               illegal_o,
	output logic                               has_ea_o,
	output logic                               has_target_o,
	output logic                               imm_o,
	output logic                               y_sel_o,
	output logic [oamd_pkg::ADDR_W-1:0]        ea_o,
	output logic [oamd_pkg::ADDR_W-1:0]        target_o,
	output logic [oamd_pkg::DATA_W-1:0]        operand_o
);
	import oamd_pkg::*;

	// ====================================================================
	// State
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_EXT  = 4'h2,
		S_PTR  = 4'h4,
		S_CALC = 4'h8
	} oamd_state_t;

	typedef struct packed {
		oamd_state_t state;
		oamd_mode_t  mode;
		logic        use_y;
		logic        y_sel;
		logic [1:0]  ext_left;
		logic [1:0]  ext_count;
		logic [1:0]  ptr_left;
		logic [7:0]  ext_hi;
		logic [7:0]  ext_lo;
		logic [15:0] ptr;
		logic [15:0] pc_next;
		logic        ready;
		logic        ext_valid;
		logic        mem_req;
		logic [15:0] mem_addr;
		logic        done;
		logic        illegal;
		logic        has_ea;
		logic        has_target;
		logic        imm;
		logic [15:0] ea;
		logic [15:0] target;
		logic [7:0]  operand;
	} oamd_st_t;

	localparam oamd_st_t ST_RST = '{
		state:      S_IDLE,
		mode:       M_INH,
		use_y:      1'b0,
		y_sel:      1'b0,
		ext_left:   CNT_RST,
		ext_count:  CNT_RST,
		ptr_left:   CNT_RST,
		ext_hi:     BYTE_RST,
		ext_lo:     BYTE_RST,
		ptr:        ADDR_RST,
		pc_next:    ADDR_RST,
		ready:      1'b1,
		ext_valid:  1'b0,
		mem_req:    1'b0,
		mem_addr:   ADDR_RST,
		done:       1'b0,
		illegal:    1'b0,
		has_ea:     1'b0,
		has_target: 1'b0,
		imm:        1'b0,
		ea:         ADDR_RST,
		target:     ADDR_RST,
		operand:    BYTE_RST
	};

	oamd_st_t st_r;
	oamd_st_t st_nxt;

	oamd_mode_t  in_mode;
	logic        in_take;
	logic        in_mode_ok;
	logic [1:0]  in_ext;
	logic [1:0]  in_ptr;
	logic        first_ext;
	logic [7:0]  ptr_addr_lo;

	// ====================================================================
	// Decode helpers
	// Here a code past the last mode is refused before it is cast to a mode; the sequencer still casts every code to in_mode.
	function automatic logic oamd_refused(input logic [MODE_W-1:0] code, input logic rmw);
		logic known;
		known        = (code <= MODE_LAST);
		oamd_refused = !known || (rmw && oamd_is_long(oamd_mode_t'(code)));
	endfunction

	// Word pointers arrive high byte first; shifting keeps byte pointers in the low half.
	function automatic logic [15:0] oamd_ptr_shift(input logic [15:0] p, input logic [7:0] b);
		oamd_ptr_shift = {p[7:0], b};
	endfunction

	// The branch base is the address just past the last extension byte.
	function automatic logic [15:0] oamd_next_pc(input logic [15:0] pc, input logic [1:0] ext);
		oamd_next_pc = pc + {14'h0000, ext} + 16'h0001;
	endfunction

	// Taking an opcode clears the operand fields, so nothing of the last instruction leaks in.
	function automatic oamd_st_t oamd_accept(input oamd_st_t s, input oamd_mode_t m, input logic [1:0] ext,
		input logic [15:0] pc);
		oamd_st_t r;
		r           = s;
		r.mode      = m;
		r.y_sel     = s.use_y && oamd_y_applies(m);
		r.use_y     = 1'b0;
		r.ext_left  = ext;
		r.ext_count = ext;
		r.ext_valid = 1'b1;
		r.ext_hi    = BYTE_RST;
		r.ext_lo    = BYTE_RST;
		r.ptr       = ADDR_RST;
		r.pc_next   = oamd_next_pc(pc, ext);
		return r;
	endfunction

	// All result fields except y_sel and illegal move on the edge of the done pulse; y_sel moves when the opcode is taken, illegal when it is refused.
	function automatic oamd_st_t oamd_finish(input oamd_st_t s, input logic [15:0] ea, input logic [15:0] tgt);
		oamd_st_t r;
		r            = s;
		r.ea         = ea;
		r.target     = tgt;
		r.has_ea     = oamd_has_ea(s.mode);
		r.has_target = oamd_has_target(s.mode);
		r.imm        = (s.mode == M_IMM);
		r.operand    = (s.mode == M_IMM) ? s.ext_hi : BYTE_RST;
		r.done       = 1'b1;
		r.state      = S_IDLE;
		r.ready      = 1'b1;
		return r;
	endfunction

	// ====================================================================
	// Address arithmetic
	oamd_ea_if ea_ifc ();

	assign ea_ifc.mode    = st_r.mode;
	assign ea_ifc.index   = st_r.y_sel ? y_i : x_i;
	assign ea_ifc.ext_hi  = st_r.ext_hi;
	assign ea_ifc.ext_lo  = st_r.ext_lo;
	assign ea_ifc.ptr     = st_r.ptr;
	assign ea_ifc.pc_next = st_r.pc_next;

	oamd_ea_calc u_calc (
		.ifc (ea_ifc)
	);

	// ====================================================================
	// Sequencer
	always_comb begin
		st_nxt      = st_r;
		in_mode     = oamd_mode_t'(fetch_mode_i);
		in_mode_ok  = !oamd_refused(fetch_mode_i, fetch_rmw_i);
		in_take     = fetch_valid_i && st_r.ready;
		in_ext      = oamd_ext_bytes(in_mode);
		in_ptr      = oamd_ptr_bytes(st_r.mode);
		first_ext   = (st_r.ext_left == st_r.ext_count);
		ptr_addr_lo = first_ext ? fetch_byte_i : st_r.ext_hi;

		st_nxt.done      = 1'b0;
		st_nxt.illegal   = 1'b0;
		st_nxt.ext_valid = 1'b0;

		case (st_r.state)
			S_IDLE: begin
				if (in_take) begin
					if (fetch_byte_i == PREFIX_Y) begin
						st_nxt.use_y = 1'b1;
					end else if (!in_mode_ok) begin
						// Refused before any extension byte is pulled, so fetch can resync at once.
						st_nxt.illegal = 1'b1;
						st_nxt.use_y   = 1'b0;
					end else begin
						st_nxt = oamd_accept(st_nxt, in_mode, in_ext, fetch_pc_i);
						if (in_ext == CNT_RST) begin
							st_nxt.state = S_CALC;
							st_nxt.ready = 1'b0;
						end else begin
							st_nxt.state = S_EXT;
						end
					end
				end
			end

			S_EXT: begin
				if (in_take) begin
					if (first_ext) begin
						st_nxt.ext_hi = fetch_byte_i;
					end else begin
						st_nxt.ext_lo = fetch_byte_i;
					end
					st_nxt.ext_left = st_r.ext_left - 2'h1;
					if (st_r.ext_left == 2'h1) begin
						st_nxt.ready = 1'b0;
						if (in_ptr != CNT_RST) begin
							st_nxt.state    = S_PTR;
							st_nxt.mem_req  = 1'b1;
							st_nxt.mem_addr = {PAGE_ZERO, ptr_addr_lo};
							st_nxt.ptr_left = in_ptr;
						end else begin
							st_nxt.state = S_CALC;
						end
					end
				end
			end

			S_PTR: begin
				if (mem_ack_i) begin
					st_nxt.ptr      = oamd_ptr_shift(st_r.ptr, mem_rdata_i);
					st_nxt.ptr_left = st_r.ptr_left - 2'h1;
					if (st_r.ptr_left == 2'h1) begin
						st_nxt.mem_req = 1'b0;
						st_nxt.state   = S_CALC;
					end else begin
						st_nxt.mem_addr = st_r.mem_addr + 16'h0001;
					end
				end
			end

			S_CALC: begin
				st_nxt = oamd_finish(st_nxt, ea_ifc.ea, ea_ifc.target);
			end

			default: begin
				st_nxt = ST_RST;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ====================================================================
	// Outputs
	assign fetch_ready_o = st_r.ready;
	assign ext_valid_o   = st_r.ext_valid;
	assign ext_count_o   = st_r.ext_count;
	assign mem_req_o     = st_r.mem_req;
	assign mem_addr_o    = st_r.mem_addr;
	assign done_o        = st_r.done;
	assign illegal_o     = st_r.illegal;
	assign has_ea_o      = st_r.has_ea;
	assign has_target_o  = st_r.has_target;
	assign imm_o         = st_r.imm;
	assign y_sel_o       = st_r.y_sel;
	assign ea_o          = st_r.ea;
	assign target_o      = st_r.target;
	assign operand_o     = st_r.operand;

endmodule
`default_nettype wire

// File: verif/oamd_mem_model.sv
// Data memory model that answers pointer reads after a chosen number of wait cycles.
`timescale 1ns/1ps
`default_nettype none
module oamd_mem_model (
	// Clock
	input  wire logic        ref_clk_i,
	// Read port
	input  wire logic        req_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [3:0]  lat_i,
	output logic             ack_o,
	output logic [7:0]       rdata_o
);
	logic [7:0] mem [256];
	logic [3:0] cnt;
	initial begin
		ack_o = 1'b0;
		rdata_o = 8'h00;
		cnt = 4'h0;
	end
	// Data off the acknowledge is inverted every cycle, so a design that samples early sees garbage.
	always @(posedge ref_clk_i) begin
		#1;
		if (req_i && cnt >= lat_i) begin
			ack_o = 1'b1;
			rdata_o = mem[addr_i[7:0]];
			cnt = 4'h0;
		end else begin
			ack_o = 1'b0;
			rdata_o = ~rdata_o;
			cnt = req_i ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// File: verif/oamd_top_chk.sv
// Checker of the operand address mode decoder, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module oamd_top_chk
	import oamd_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	// Fetch stream
	input wire logic        fetch_valid_i,
	input wire logic [4:0]  fetch_mode_i,
	input wire logic        fetch_rmw_i,
	input wire logic        fetch_ready_o,
	input wire logic        ext_valid_o,
	input wire logic [1:0]  ext_count_o,
	// Index and memory
	input wire logic [7:0]  x_i,
	input wire logic [7:0]  y_i,
	input wire logic        mem_req_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        mem_ack_i,
	// Results
	input wire logic        done_o,
	input wire logic        illegal_o,
	input wire logic        imm_o,
	input wire logic        y_sel_o,
	input wire logic [15:0] ea_o
);
	logic [4:0] take_m_r;
	logic [4:0] mode_r;
	logic       long_c;
	logic       take_c;
	logic       rmwl_c;
	logic       bad_c;
	logic [7:0] idx_c;
	function automatic logic [1:0] cnt_f(input logic [4:0] m);
		return (m inside {M_INH, M_IDX_0}) ? 2'h0 : (m inside {M_DIR_L, M_IDX_L, M_BTJ_D, M_BTJ_I}) ? 2'h2 : 2'h1;
	endfunction
	assign long_c = fetch_mode_i inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIX_L};
	assign take_c = fetch_valid_i && fetch_ready_o;
	assign rmwl_c = fetch_rmw_i && long_c;
	assign bad_c  = rmwl_c || (fetch_mode_i > MODE_LAST);
	assign idx_c  = y_sel_o ? y_i : x_i;
	// ====================================================================
	// Mode of the instruction in flight, since the results carry no mode.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			take_m_r <= 5'h00;
			mode_r <= 5'h00;
		end else begin
			if (fetch_valid_i && fetch_ready_o) take_m_r <= fetch_mode_i;
			if (ext_valid_o) mode_r <= take_m_r;
		end
	end
	// ====================================================================
	// Properties
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_take; ext_valid_o |-> $past(take_c); endproperty
	a_take: assert property (p_take) else $error("count pulse without a taken opcode");
	property p_cnt; ext_valid_o |-> ext_count_o == cnt_f(take_m_r); endproperty
	a_cnt: assert property (p_cnt) else $error("wrong extension count");
	property p_inh; ext_valid_o && ext_count_o == 2'h0 |-> !fetch_ready_o ##1 done_o; endproperty
	a_inh: assert property (p_inh) else $error("no-extension opcode not done at once");
	property p_page; done_o && mode_r inside {M_DIR_S, M_IDX_0, M_IND_S, M_BIT_D, M_BTJ_D} |-> ea_o[15:8] == 8'h00; endproperty
	a_page: assert property (p_page) else $error("short address left page zero");
	property p_idx0; done_o && mode_r == M_IDX_0 |-> ea_o == {8'h00, $past(idx_c)}; endproperty
	a_idx0: assert property (p_idx0) else $error("index-only address wrong");
	property p_idxs; done_o && mode_r inside {M_IDX_S, M_IIX_S} |-> ea_o <= 16'h01FE; endproperty
	a_idxs: assert property (p_idxs) else $error("short indexed address above 1FE");
	property p_imm; done_o |-> imm_o == (mode_r == M_IMM); endproperty
	a_imm: assert property (p_imm) else $error("immediate flag wrong");
	property p_ill; illegal_o |-> $past(bad_c); endproperty
	a_ill: assert property (p_ill) else $error("legal opcode refused");
	property p_legal; ext_valid_o |-> !$past(rmwl_c); endproperty
	a_legal: assert property (p_legal) else $error("long mode accepted for read-modify-write");
	property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
	a_hold: assert property (p_hold) else $error("read request dropped or moved");
	c_long: cover property (ext_valid_o && ext_count_o == 2'h2);
	c_ill: cover property (illegal_o);
	c_ptr: cover property (mem_req_o && mem_ack_i);
endmodule
bind oamd_top oamd_top_chk u_oamd_top_chk (.ref_clk_i, .rst_i, .fetch_valid_i, .fetch_mode_i, .fetch_rmw_i,
	.fetch_ready_o, .ext_valid_o, .ext_count_o, .x_i, .y_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .done_o,
	.illegal_o, .imm_o, .y_sel_o, .ea_o);
`default_nettype wire

// File: verif/oamd_top_bench.sv
// Self-checking testbench of the operand address mode decoder.
`timescale 1ns/1ps
`default_nettype none
module oamd_top_bench;
	import oamd_pkg::*;
	logic        ref_clk_i, rst_i, fetch_valid_i, fetch_rmw_i, fetch_ready_o, ext_valid_o, mem_req_o, mem_ack_i;
	logic        done_o, illegal_o, has_ea_o, has_target_o, imm_o, y_sel_o, got_end, got_ill;
	logic [7:0]  fetch_byte_i, x_i, y_i, mem_rdata_i, operand_o;
	logic [15:0] fetch_pc_i, mem_addr_o, ea_o, target_o;
	logic [4:0]  fetch_mode_i;
	logic [1:0]  ext_count_o, got_cnt;
	logic [3:0]  lat;
	int          n_errors, checked;
	oamd_top u_oamd_top (.ref_clk_i, .rst_i, .fetch_valid_i, .fetch_byte_i, .fetch_pc_i, .fetch_mode_i, .fetch_rmw_i,
		.fetch_ready_o, .ext_valid_o, .ext_count_o, .x_i, .y_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i,
		.done_o, .illegal_o, .has_ea_o, .has_target_o, .imm_o, .y_sel_o, .ea_o, .target_o, .operand_o);
	oamd_mem_model u_oamd_mem_model (.ref_clk_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .lat_i(lat),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	// ====================================================================
	// Shared tasks
	function automatic logic [1:0] ext_n(input logic [4:0] m, input logic rmw);
		if (m > 5'h10 || (rmw && m inside {M_DIR_L, M_IDX_L, M_IND_L, M_IIX_L})) return 2'h0;
		return (m inside {M_INH, M_IDX_0}) ? 2'h0 : (m inside {M_DIR_L, M_IDX_L, M_BTJ_D, M_BTJ_I}) ? 2'h2 : 2'h1;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			n_errors++;
		end
		checked++;
	endtask
	// Valid stays up between bytes, so no signal is assigned twice in one step.
	task automatic put(input logic [7:0] b);
		fetch_byte_i = b;
		fetch_valid_i = 1'b1;
		while (fetch_ready_o !== 1'b1) begin
			@(posedge ref_clk_i);
			#1;
		end
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic instr(input logic [4:0] m, input logic rmw, input logic pfx, input logic [15:0] pc,
		input logic [7:0] b1, input logic [7:0] b2);
		logic [1:0] n;
		n = ext_n(m, rmw);
		got_cnt = 2'h3;
		got_ill = 1'b0;
		got_end = 1'b0;
		fetch_mode_i = m;
		fetch_rmw_i = rmw;
		fetch_pc_i = pc;
		if (pfx) put(PREFIX_Y);
		put(8'h00);
		if (n > 2'h0) put(b1);
		if (n > 2'h1) put(b2);
		fetch_valid_i = 1'b0;
		for (int i = 0; i < 40 && !got_end; i++) begin
			@(posedge ref_clk_i);
			#1;
		end
		if (!got_end) check(16'h0000, 16'h0001);
	endtask
	always @(posedge ref_clk_i) begin
		if (ext_valid_o === 1'b1) got_cnt = ext_count_o;
		if (illegal_o === 1'b1) got_ill = 1'b1;
		if (done_o === 1'b1 || illegal_o === 1'b1) got_end = 1'b1;
	end
	// ====================================================================
	// Scenarios
	task automatic s_modes;
		for (int m = 0; m < 17; m++) begin
			instr(5'(m), 1'b0, 1'b0, 16'h1000, 8'h20, 8'h05);
			check(16'(got_cnt), 16'(ext_n(5'(m), 1'b0)));
			check(16'(has_ea_o), 16'(!(m inside {0, 1, 11, 12})));
		end
	endtask
	task automatic s_index;
		instr(M_IDX_0, 1'b0, 1'b0, 16'h1000, 8'h00, 8'h00);
		check(ea_o, 16'h007F);
		check(16'(y_sel_o), 16'h0000);
		instr(M_IDX_S, 1'b0, 1'b1, 16'h1000, 8'hFF, 8'h00);
		check(ea_o, 16'h01FE);
		check(16'(y_sel_o), 16'h0001);
		instr(M_IMM, 1'b0, 1'b0, 16'h1000, 8'h55, 8'h00);
		check(16'(operand_o), 16'h0055);
	endtask
	task automatic s_long;
		instr(M_DIR_L, 1'b0, 1'b0, 16'h1000, 8'h12, 8'h34);
		check(ea_o, 16'h1234);
		instr(M_IDX_L, 1'b0, 1'b0, 16'h1000, 8'hFF, 8'hC0);
		check(ea_o, 16'h003F);
		instr(M_DIR_S, 1'b0, 1'b0, 16'h1000, 8'hAB, 8'h00);
		check(ea_o, 16'h00AB);
	endtask
	// Slow memory first, then prompt answers back to back on a word pointer.
	task automatic s_ptr;
		lat = 4'h3;
		instr(M_IND_L, 1'b0, 1'b0, 16'h1000, 8'hFE, 8'h00);
		check(ea_o, 16'h5B5A);
		instr(M_IIX_S, 1'b0, 1'b0, 16'h1000, 8'h10, 8'h00);
		check(ea_o, 16'h0134);
		instr(M_IND_S, 1'b0, 1'b0, 16'h1000, 8'h20, 8'h00);
		check(ea_o, 16'h0085);
		lat = 4'h0;
		instr(M_IIX_L, 1'b0, 1'b0, 16'h1000, 8'h40, 8'h00);
		check(ea_o, 16'hE663);
	endtask
	task automatic s_rel;
		instr(M_REL_D, 1'b0, 1'b0, 16'h1000, 8'h80, 8'h00);
		check(target_o, 16'h0F82);
		check(16'(has_target_o), 16'h0001);
		instr(M_REL_D, 1'b0, 1'b0, 16'h1000, 8'h7F, 8'h00);
		check(target_o, 16'h1081);
		instr(M_REL_I, 1'b0, 1'b0, 16'h1000, 8'h30, 8'h00);
		check(target_o, 16'h0F97);
		instr(M_BTJ_D, 1'b0, 1'b0, 16'h2000, 8'h44, 8'h7F);
		check(ea_o, 16'h0044);
		check(target_o, 16'h2082);
	endtask
	task automatic s_refuse;
		instr(M_DIR_L, 1'b1, 1'b0, 16'h1000, 8'h12, 8'h34);
		check(16'(got_ill), 16'h0001);
		instr(5'h11, 1'b0, 1'b0, 16'h1000, 8'h00, 8'h00);
		check(16'(got_ill), 16'h0001);
		instr(M_DIR_S, 1'b1, 1'b0, 16'h1000, 8'h3C, 8'h00);
		check(16'(got_ill), 16'h0000);
		check(ea_o, 16'h003C);
	endtask
	task automatic final_report;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ====================================================================
	// Clock, watchdog and main sequence
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#100000;
		n_errors++;
		final_report;
	end
	initial begin
		{rst_i, fetch_valid_i, fetch_rmw_i, fetch_byte_i, fetch_pc_i, fetch_mode_i} = {1'b1, 31'h0000_0000};
		{x_i, y_i, lat, n_errors, checked} = {8'h7F, 8'hFF, 4'h0, 32'h0000_0000, 32'h0000_0000};
		for (int i = 0; i < 256; i++) u_oamd_mem_model.mem[i] = 8'(i) ^ 8'hA5;
		repeat (2) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		s_modes;
		s_index;
		s_long;
		s_ptr;
		s_rel;
		s_refuse;
		final_report;
	end
endmodule
`default_nettype wire
